// File: verilog/dtc_timer.sv
// dual timer/counter with external interrupt sensing and an AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module dtc_timer (
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic                         timer0_count_pin,
	input  wire logic                         timer1_count_pin,
	input  wire logic                         ext_irq0_pin,
	input  wire logic                         ext_irq1_pin,
	output logic                              ext_irq0_active,
	output logic                              ext_irq1_active,
	output logic                              irq,
	input  wire logic [dtc_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [dtc_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready
);
	import dtc_pkg::*;

	logic [7:0]        ctl_q;          // run, flags, trigger selects
	logic [7:0]        mode_q;
	logic [7:0]        t0l_q, t0h_q, t1l_q, t1h_q;
	logic [EV_N-1:0]   mask_q;
	logic [EV_N-1:0]   ev_q;           // sticky interrupt status
	logic              tick_q;         // divide-by-two timer tick
	logic              c0_q, c1_q, i0_q, i1_q;   // previous pin samples
	dtc_wstate_t       wst_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0]       wdata_q;
	logic              aw_have_q, w_have_q;

	logic              wr_en;
	logic [7:0]        widx;
	logic              wr_ok;
	logic [EV_N-1:0]   ack;
	logic [3:0]        wstrb_q;        // byte strobes of the taken write
	dtc_mode_t         m0, m1;
	logic              en0, en1, en0h;
	logic              inc0, inc1, inc0h;
	logic              irq0_fall, irq1_fall;
	logic [7:0]        t0l_d, t0h_d, t1l_d, t1h_d;
	logic              ovf0, ovf1;

	// a write lands only in its one execute cycle and only at a mapped address;
	// without the address check the upper address bits would alias onto the map
	assign widx  = waddr_q[9:2];
	assign wr_en = (wst_q == DTC_W_DO) && wr_ok;
	assign wr_ok = (waddr_q[ADDR_W-1:10] == '0) && (widx == IDX_TIMER_CONTROL ||
		widx == IDX_TIMER_MODE || widx == IDX_T0_LOW || widx == IDX_T1_LOW ||
		widx == IDX_T0_HIGH || widx == IDX_T1_HIGH || widx == IDX_IRQ_STATUS ||
		widx == IDX_IRQ_MASK || widx == IDX_VECTOR_ACK);
	// vector acknowledge: the processor entering a service routine clears a flag
	assign ack = (wr_en && widx == IDX_VECTOR_ACK && wstrb_q[0]) ? wdata_q[EV_N-1:0] : '0;

	// count enables: run bit, optionally gated by the interrupt pin
	assign m0    = dtc_mode_t'(mode_q[MOD_M0_HI:MOD_M0_LO]);
	assign m1    = dtc_mode_t'(mode_q[MOD_M1_HI:MOD_M1_LO]);
	// the gate pin is read directly, so a gate pulse shorter than a tick may
	// still let one count through; software must not rely on finer gating
	assign en0   = ctl_q[CTL_RUN0] && (!mode_q[MOD_GATING0] || ext_irq0_pin);
	assign en1   = ctl_q[CTL_RUN1] && (!mode_q[MOD_GATING1] || ext_irq1_pin) &&
		(m1 != DTC_MODE_SPLIT);
	// the split high byte borrows timer 1's run bit and is never pin gated
	assign en0h  = ctl_q[CTL_RUN1];
	// count sources: tick every two clocks or count-pin falling edge
	assign inc0  = en0 && (mode_q[MOD_CT0] ? (c0_q && !timer0_count_pin) : tick_q);
	assign inc1  = en1 && (mode_q[MOD_CT1] ? (c1_q && !timer1_count_pin) : tick_q);
	assign inc0h = en0h && tick_q;
	// pin history resets high, the idle level, so reset never fakes an edge;
	// a low pulse must span one clock edge to be seen at all
	assign irq0_fall = i0_q && !ext_irq0_pin;
	assign irq1_fall = i1_q && !ext_irq1_pin;

	// timer 0 next value and overflow, per mode
	always_comb begin
		t0l_d = t0l_q;
		t0h_d = t0h_q;
		ovf0  = 1'b0;
		ovf1  = 1'b0;
		case (m0)
			DTC_MODE_PRESC13: begin
				if (inc0) begin
					t0l_d = {t0l_q[7:5], t0l_q[4:0] + 5'd1};
					if (t0l_q[4:0] == PRESC_MAX) begin
						t0h_d = t0h_q + 8'd1;
						ovf0  = (t0h_q == 8'hff);
					end
				end
			end
			DTC_MODE_16BIT: begin
				if (inc0) begin
					{t0h_d, t0l_d} = {t0h_q, t0l_q} + 16'd1;
					ovf0 = ({t0h_q, t0l_q} == 16'hffff);
				end
			end
			DTC_MODE_RELOAD8: begin
				if (inc0) begin
					t0l_d = (t0l_q == 8'hff) ? t0h_q : t0l_q + 8'd1;
					ovf0  = (t0l_q == 8'hff);
				end
			end
			DTC_MODE_SPLIT: begin
				if (inc0) begin
					t0l_d = t0l_q + 8'd1;
					ovf0  = (t0l_q == 8'hff);
				end
				if (inc0h) begin
					t0h_d = t0h_q + 8'd1;
					ovf1  = (t0h_q == 8'hff);
				end
			end
			default: begin
				t0l_d = t0l_q;
			end
		endcase
	end

	// timer 1 next value and overflow, per mode
	logic ovf1_own;
	always_comb begin
		t1l_d    = t1l_q;
		t1h_d    = t1h_q;
		ovf1_own = 1'b0;
		case (m1)
			DTC_MODE_PRESC13: begin
				if (inc1) begin
					t1l_d = {t1l_q[7:5], t1l_q[4:0] + 5'd1};
					if (t1l_q[4:0] == PRESC_MAX) begin
						t1h_d    = t1h_q + 8'd1;
						ovf1_own = (t1h_q == 8'hff);
					end
				end
			end
			DTC_MODE_16BIT: begin
				if (inc1) begin
					{t1h_d, t1l_d} = {t1h_q, t1l_q} + 16'd1;
					ovf1_own = ({t1h_q, t1l_q} == 16'hffff);
				end
			end
			DTC_MODE_RELOAD8: begin
				if (inc1) begin
					t1l_d    = (t1l_q == 8'hff) ? t1h_q : t1l_q + 8'd1;
					ovf1_own = (t1l_q == 8'hff);
				end
			end
			default: begin // holds value
				t1l_d = t1l_q;
			end
		endcase
	end

	// divide-by-two tick and pin history
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tick_q <= TICK_RST;
			c0_q   <= 1'b1;
			c1_q   <= 1'b1;
			i0_q   <= 1'b1;
			i1_q   <= 1'b1;
		end else begin
			tick_q <= !tick_q;
			c0_q   <= timer0_count_pin;
			c1_q   <= timer1_count_pin;
			i0_q   <= ext_irq0_pin;
			i1_q   <= ext_irq1_pin;
		end
	end

	// data bytes: software write wins over counting in the same cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			t0l_q <= RST_BYTE;
			t0h_q <= RST_BYTE;
			t1l_q <= RST_BYTE;
			t1h_q <= RST_BYTE;
		end else begin
			t0l_q <= (wr_en && widx == IDX_T0_LOW  && wstrb_q[0]) ? wdata_q[7:0] : t0l_d;
			t0h_q <= (wr_en && widx == IDX_T0_HIGH && wstrb_q[0]) ? wdata_q[7:0] : t0h_d;
			t1l_q <= (wr_en && widx == IDX_T1_LOW  && wstrb_q[0]) ? wdata_q[7:0] : t1l_d;
			t1h_q <= (wr_en && widx == IDX_T1_HIGH && wstrb_q[0]) ? wdata_q[7:0] : t1h_d;
		end
	end

	// control register: hardware set beats clear by software or acknowledge
	logic [7:0] ctl_w;
	logic [7:0] hw_set;
	logic [7:0] hw_clr;
	always_comb begin
		ctl_w  = (wr_en && widx == IDX_TIMER_CONTROL && wstrb_q[0]) ? wdata_q[7:0] : ctl_q;
		hw_set = '0;
		hw_clr = '0;
		// an overflow or edge in the same cycle as a clear keeps its flag,
		// so an event is never lost to a late acknowledge
		hw_set[CTL_OVF0]  = ovf0;
		hw_set[CTL_OVF1]  = ovf1_own || ovf1;
		hw_set[CTL_EDGE0] = ctl_q[CTL_TRIG0] && irq0_fall;
		hw_set[CTL_EDGE1] = ctl_q[CTL_TRIG1] && irq1_fall;
		hw_clr[CTL_OVF0]  = ack[EV_OVF0];
		hw_clr[CTL_OVF1]  = ack[EV_OVF1];
		hw_clr[CTL_EDGE0] = ack[EV_EDGE0];
		hw_clr[CTL_EDGE1] = ack[EV_EDGE1];
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctl_q  <= RST_BYTE;
			mode_q <= RST_BYTE;
		end else begin
			ctl_q <= (ctl_w & ~hw_clr) | hw_set;
			if (wr_en && widx == IDX_TIMER_MODE && wstrb_q[0]) begin
				mode_q <= wdata_q[7:0];
			end
		end
	end

	// active interrupt requests: low level or edge flag per select bit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ext_irq0_active <= 1'b0;
			ext_irq1_active <= 1'b0;
		end else begin
			// level mode follows the pin one clock late; edge mode shows the flag
			ext_irq0_active <= ctl_q[CTL_TRIG0] ? ctl_q[CTL_EDGE0] : !ext_irq0_pin;
			ext_irq1_active <= ctl_q[CTL_TRIG1] ? ctl_q[CTL_EDGE1] : !ext_irq1_pin;
		end
	end

	// sticky status, write one to clear, set wins; mask; level interrupt
	logic [EV_N-1:0] ev_set;
	// status mirrors the hardware set events, so clearing a control flag by
	// acknowledge leaves the sticky status for software to clear on its own
	assign ev_set = {hw_set[CTL_EDGE1], hw_set[CTL_EDGE0], hw_set[CTL_OVF1], hw_set[CTL_OVF0]};
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ev_q   <= RST_EV;
			mask_q <= RST_EV;
			irq    <= 1'b0;
		end else begin
			if (wr_en && widx == IDX_IRQ_STATUS && wstrb_q[0]) begin
				ev_q <= (ev_q & ~wdata_q[EV_N-1:0]) | ev_set;
			end else begin
				ev_q <= ev_q | ev_set;
			end
			if (wr_en && widx == IDX_IRQ_MASK && wstrb_q[0]) begin
				mask_q <= wdata_q[EV_N-1:0];
			end
			irq <= |(ev_q & mask_q);
		end
	end

	// write path: address and data taken in either order, then one response
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wst_q         <= DTC_W_IDLE;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			waddr_q       <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			case (wst_q)
				DTC_W_IDLE: begin
					s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
					s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
					if (s_axi_awvalid && s_axi_awready) begin
						aw_have_q <= 1'b1;
						waddr_q   <= s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_have_q <= 1'b1;
						wdata_q  <= s_axi_wdata;
						wstrb_q  <= s_axi_wstrb;
					end
					if ((aw_have_q || (s_axi_awvalid && s_axi_awready)) &&
						(w_have_q || (s_axi_wvalid && s_axi_wready))) begin
						wst_q         <= DTC_W_DO;
						s_axi_awready <= 1'b0;
						s_axi_wready  <= 1'b0;
					end
				end
				DTC_W_DO: begin
					aw_have_q    <= 1'b0;
					w_have_q     <= 1'b0;
					s_axi_bvalid <= 1'b1;
					s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
					wst_q        <= DTC_W_RESP;
				end
				DTC_W_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wst_q        <= DTC_W_IDLE;
					end
				end
				default: wst_q <= DTC_W_IDLE;
			endcase
		end
	end

	// read path: one cycle after the address is taken, held until rready
	logic [7:0]  ridx;
	logic [31:0] rmux;
	logic        rok;
	assign ridx = s_axi_araddr[9:2];
	always_comb begin
		rmux = '0;
		rok  = (s_axi_araddr[ADDR_W-1:10] == '0);
		case (ridx)
			IDX_TIMER_CONTROL: rmux[7:0] = ctl_q;
			IDX_TIMER_MODE:    rmux[7:0] = mode_q;
			IDX_T0_LOW:        rmux[7:0] = t0l_q;
			IDX_T1_LOW:        rmux[7:0] = t1l_q;
			IDX_T0_HIGH:       rmux[7:0] = t0h_q;
			IDX_T1_HIGH:       rmux[7:0] = t1h_q;
			IDX_IRQ_STATUS:    rmux[EV_N-1:0] = ev_q;
			IDX_IRQ_MASK:      rmux[EV_N-1:0] = mask_q;
			IDX_VECTOR_ACK:    rmux = '0;
			default:           rok = 1'b0;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rmux;
				s_axi_rresp   <= rok ? RESP_OKAY : RESP_SLVERR;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : dtc_timer
`default_nettype wire

// File: verilog/dtc_pkg.sv
// package for the dual timer/counter block: register map, fields, reset values
package dtc_pkg;
	// printed offsets are not multiples of four: they are indices, byte address = 4*index
	localparam logic [7:0]  IDX_TIMER_CONTROL   = 8'h88;
	localparam logic [7:0]  IDX_TIMER_MODE      = 8'h89;
	localparam logic [7:0]  IDX_T0_LOW          = 8'h8a;
	localparam logic [7:0]  IDX_T1_LOW          = 8'h8b;
	localparam logic [7:0]  IDX_T0_HIGH         = 8'h8c;
	localparam logic [7:0]  IDX_T1_HIGH         = 8'h8d;
	localparam logic [7:0]  IDX_IRQ_STATUS      = 8'hc0;
	localparam logic [7:0]  IDX_IRQ_MASK        = 8'hc1;
	localparam logic [7:0]  IDX_VECTOR_ACK      = 8'hc2;
	localparam int          ADDR_W              = 12;
	// control register fields
	localparam int          CTL_OVF1            = 7;
	localparam int          CTL_RUN1            = 6;
	localparam int          CTL_OVF0            = 5;
	localparam int          CTL_RUN0            = 4;
	localparam int          CTL_EDGE1           = 3;
	localparam int          CTL_TRIG1           = 2;
	localparam int          CTL_EDGE0           = 1;
	localparam int          CTL_TRIG0           = 0;
	// mode register fields
	localparam int          MOD_GATING1         = 7;
	localparam int          MOD_CT1             = 6;
	localparam int          MOD_M1_HI           = 5;
	localparam int          MOD_M1_LO           = 4;
	localparam int          MOD_GATING0         = 3;
	localparam int          MOD_CT0             = 2;
	localparam int          MOD_M0_HI           = 1;
	localparam int          MOD_M0_LO           = 0;
	// interrupt status / ack bits
	localparam int          EV_OVF0             = 0;
	localparam int          EV_OVF1             = 1;
	localparam int          EV_EDGE0            = 2;
	localparam int          EV_EDGE1            = 3;
	localparam int          EV_N                = 4;
	// reset values
	localparam logic [7:0]  RST_BYTE            = 8'h00;
	localparam logic [3:0]  RST_EV              = 4'h0;
	localparam logic [1:0]  RESP_OKAY           = 2'b00;
	localparam logic [1:0]  RESP_SLVERR         = 2'b10;
	// timer mode encodings
	typedef enum logic [1:0] {
		DTC_MODE_PRESC13 = 2'b00,
		DTC_MODE_16BIT   = 2'b01,
		DTC_MODE_RELOAD8 = 2'b10,
		DTC_MODE_SPLIT   = 2'b11
	} dtc_mode_t;
	// bus write state
	typedef enum logic [2:0] {
		DTC_W_IDLE = 3'b001,
		DTC_W_DO   = 3'b010,
		DTC_W_RESP = 3'b100
	} dtc_wstate_t;
	localparam logic [4:0]  PRESC_MAX           = 5'h1f;
	localparam logic        TICK_RST            = 1'b0;
endpackage : dtc_pkg

// File: verif/dtc_timer_assertions.sv
// checker for the register bus handshakes of the timer block
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_assertions (
	input wire logic                       clk_sys,
	input wire logic                       reset,
	input wire logic [dtc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [dtc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready
);
	import dtc_pkg::*;
	localparam logic [11:0] ERR_ADDR = 12'h3fc;
	// both write channels taken together, and a read address taken
	wire logic aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic ar_go = s_axi_arvalid && s_axi_arready;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// answer timing, holding and refusal of the register bus
	a_read_latency: assert property (ar_go |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_latency: assert property (aw_go |=> ##[0:1] s_axi_bvalid)
		else $error("write answer late");
	a_bresp_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_rdata_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_read_closed: assert property (ar_go |=> !s_axi_arready)
		else $error("read address taken while busy");
	a_write_refused: assert property (
		aw_go && s_axi_awaddr == ERR_ADDR |=> ##[0:1] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
		else $error("unmapped write not refused");
	a_read_refused: assert property (
		ar_go && s_axi_araddr == ERR_ADDR |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_upper_zero: assert property (
		s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	c_write: cover property (aw_go);
	c_read: cover property (ar_go);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : dtc_timer_assertions
bind dtc_timer dtc_timer_assertions i_dtc_timer_assertions (
	.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: verif/dtc_pins_model.sv
// model of the external count and interrupt pins
`timescale 1ns/100ps
`default_nettype none
module dtc_pins_model (
	input wire logic       clk_sys,
	input wire logic [1:0] pulse_req,
	input wire logic [1:0] irq_lvl,
	output logic           timer0_count_pin,
	output logic           timer1_count_pin,
	output logic           ext_irq0_pin,
	output logic           ext_irq1_pin
);
	logic [1:0] low0_q = 2'b00;
	logic [1:0] low1_q = 2'b00;
	// a request holds a count pin low three clocks, giving one negative edge
	always_ff @(posedge clk_sys) begin
		if (pulse_req[0]) low0_q <= 2'b11;
		else if (low0_q != 2'b00) low0_q <= low0_q - 2'b01;
		if (pulse_req[1]) low1_q <= 2'b11;
		else if (low1_q != 2'b00) low1_q <= low1_q - 2'b01;
	end
	// pins idle high between pulses
	assign timer0_count_pin = (low0_q == 2'b00);
	assign timer1_count_pin = (low1_q == 2'b00);
	assign ext_irq0_pin = irq_lvl[0];
	assign ext_irq1_pin = irq_lvl[1];
endmodule : dtc_pins_model
`default_nettype wire

// File: verif/dtc_timer_tb.sv
// self-checking bench for the dual timer/counter block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module dtc_timer_tb;
	import dtc_pkg::*;
	localparam logic [7:0] CT = IDX_TIMER_CONTROL, MD = IDX_TIMER_MODE;
	localparam logic [7:0] L0 = IDX_T0_LOW, H0 = IDX_T0_HIGH, L1 = IDX_T1_LOW, H1 = IDX_T1_HIGH;
	logic              clk_sys = 1'b0, reset = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0]       wdata = '0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0]        pulse_req = 2'b00, irq_lvl = 2'b11;
	logic [7:0]        regs [5] = '{MD, L0, L1, H0, H1};
	wire logic         t0p, t1p, x0p, x1p, x0_act, x1_act, irq, awready, wready, bvalid;
	wire logic         arready, rvalid;
	wire logic [1:0]   bresp, rresp;
	wire logic [31:0]  rdata;
	int                n_mismatch = 0, num_checks = 0;
	dtc_pins_model i_dtc_pins_model (.clk_sys(clk_sys), .pulse_req(pulse_req), .irq_lvl(irq_lvl),
		.timer0_count_pin(t0p), .timer1_count_pin(t1p), .ext_irq0_pin(x0p), .ext_irq1_pin(x1p));
	dtc_timer i_dtc_timer (.clk_sys(clk_sys), .reset(reset), .timer0_count_pin(t0p),
		.timer1_count_pin(t1p), .ext_irq0_pin(x0p), .ext_irq1_pin(x1p), .ext_irq0_active(x0_act),
		.ext_irq1_active(x1_act), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	always #10 clk_sys = ~clk_sys;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	// a wait that ran out ends the run
	task automatic tmo(input int n);
		if (n >= 64) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : tmo
	// register write: address and data offered together, held until taken
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64 && bvalid !== 1'b1; n++) begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		tmo(n);
		`CHK(bresp, er)
		bready <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	// register read compared with its expected byte
	task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
		int n;
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64 && rvalid !== 1'b1; n++) begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end
		tmo(n);
		`CHK(rresp, er)
		if (er == RESP_OKAY) `CHK(rdata, {24'h00_0000, e})
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask : rd
	// k negative edges on the selected count pins
	task automatic pulse(input logic [1:0] m, input int k);
		repeat (k) begin
			pulse_req <= m;
			@(posedge clk_sys);
			pulse_req <= 2'b00;
			repeat (7) @(posedge clk_sys);
		end
	endtask : pulse
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			rd(regs[i], 8'h00);
			wr(regs[i], {4'h5, 4'(i)});
			rd(regs[i], {4'h5, 4'(i)});
		end
		wr(8'hff, 8'h01, RESP_SLVERR);
		rd(8'hff, 8'h00, RESP_SLVERR);
	endtask : t_regs
	task automatic t_m16();
		wr(MD, 8'h05);
		wr(L0, 8'hfe);
		wr(H0, 8'hff);
		wr(CT, 8'h10);
		pulse(2'b01, 3);
		rd(L0, 8'h01);
		rd(H0, 8'h00);
		rd(CT, 8'h30);
		rd(IDX_IRQ_STATUS, 8'h01);
		`CHK(irq, 1'b0)
		wr(IDX_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		wr(IDX_VECTOR_ACK, 8'h01);
		wr(IDX_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		rd(CT, 8'h10);
		wr(CT, 8'h00);
	endtask : t_m16
	task automatic t_modes();
		wr(MD, 8'h46);
		wr(L1, 8'h1e);
		wr(H1, 8'h07);
		wr(L0, 8'hfe);
		wr(H0, 8'ha0);
		wr(CT, 8'h50);
		pulse(2'b11, 3);
		rd(L1, 8'h01);
		rd(H1, 8'h08);
		rd(L0, 8'ha1);
		rd(H0, 8'ha0);
		rd(CT, 8'h70);
		wr(CT, 8'h00);
	endtask : t_modes
	task automatic t_gate();
		wr(MD, 8'h7d);
		wr(L0, 8'h00);
		wr(CT, 8'h50);
		irq_lvl <= 2'b10;
		pulse(2'b11, 2);
		rd(L1, 8'h01);
		rd(L0, 8'h00);
		irq_lvl <= 2'b11;
		repeat (4) @(posedge clk_sys);
		pulse(2'b01, 2);
		rd(L0, 8'h02);
		wr(CT, 8'h00);
		pulse(2'b01, 1);
		rd(L0, 8'h02);
	endtask : t_gate
	task automatic t_ext();
		`CHK(x0_act, 1'b0)
		wr(CT, 8'h01);
		irq_lvl <= 2'b10;
		repeat (4) @(posedge clk_sys);
		irq_lvl <= 2'b11;
		repeat (4) @(posedge clk_sys);
		`CHK(x0_act, 1'b1)
		rd(CT, 8'h03);
		wr(IDX_VECTOR_ACK, 8'h04);
		rd(CT, 8'h01);
		irq_lvl <= 2'b01;
		repeat (4) @(posedge clk_sys);
		`CHK(x1_act, 1'b1)
		irq_lvl <= 2'b11;
		repeat (4) @(posedge clk_sys);
		`CHK(x1_act, 1'b0)
		wr(CT, 8'h04);
		irq_lvl <= 2'b01;
		repeat (4) @(posedge clk_sys);
		irq_lvl <= 2'b11;
		repeat (4) @(posedge clk_sys);
		`CHK(x1_act, 1'b1)
		rd(CT, 8'h0c);
		wr(IDX_VECTOR_ACK, 8'h08);
		rd(CT, 8'h04);
	endtask : t_ext
	// split mode: low byte on its own run bit, high byte on timer 1's run bit and flag
	task automatic t_split();
		wr(IDX_IRQ_STATUS, 8'h0f);
		wr(MD, 8'h33);
		wr(L0, 8'hff);
		wr(H0, 8'hff);
		wr(CT, 8'h10);
		wr(CT, 8'h00);
		rd(L0, 8'h01);
		rd(H0, 8'hff);
		wr(CT, 8'h40);
		wr(CT, 8'h00);
		rd(H0, 8'h01);
		rd(L0, 8'h01);
		rd(L1, 8'h01);
		rd(IDX_IRQ_STATUS, 8'h03);
		`CHK(irq, 1'b1)
	endtask : t_split
	// timer 1 gated by the interrupt-1 pin
	task automatic t_timer1_pin_gating();
		wr(MD, 8'hd5);
		wr(CT, 8'h40);
		irq_lvl <= 2'b01;
		pulse(2'b10, 1);
		rd(L1, 8'h01);
		irq_lvl <= 2'b11;
		repeat (4) @(posedge clk_sys);
		pulse(2'b10, 1);
		rd(L1, 8'h02);
		wr(CT, 8'h00);
	endtask : t_timer1_pin_gating
	// reset, then the scenarios in turn
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_m16();
		t_modes();
		t_gate();
		t_ext();
		t_split();
		t_timer1_pin_gating();
		print_verdict();
	end
endmodule : dtc_timer_tb
`default_nettype wire
